//--- rtl/dac_load_pkg.sv
// Types for the serial load chain of the converter.
package dac_load_pkg;
	typedef enum logic [1:0] {
		frame_idle   = 2'b00,
		frame_active = 2'b01,
		frame_locked = 2'b10
	} frame_state_t;
	typedef logic [15:0] word_t;
endpackage

//--- rtl/dac_load_regs.svh
// Constants for the serial load chain of the converter.
`ifndef DAC_LOAD_REGS_SVH
`define DAC_LOAD_REGS_SVH
`define WORD_BITS 16
`define WORD_RESET 16'h0000
`define FIFO_DEPTH 32
`define MCLK_PERIOD_NS 25
`define HOLD_TIME_NS 5000
`define HOLD_CYCLES ((`HOLD_TIME_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)
`endif

//--- rtl/dac_serial_load_chain.sv
// Serial input register, converter latch and output hold of the converter.
`timescale 1ns/1ps
`default_nettype none
`include "dac_load_regs.svh"
// Summary of operation
// - Chain select high disables the sixteen-edge gate and enables the serial output.
// - In chain mode every falling clock edge while sync is low shifts a bit.
// - In chain mode bits past sixteen edges leave on the serial output.
// - Sync high makes the device ignore clock edges and keep the register.
// - Falling edge of the load strobe copies the input register to the latch.
// - After a strobe edge outside a running hold the output keeps its old value for 5 us, or until an automatic full-word update.
// - Clear low zeroes the latch directly, leaving the shift register untouched.
// - Clear acts apart from the power-on reset; neither triggers the other.
// - Latch updates either automatically after a full word or by the strobe.
// - Standalone mode accepts exactly sixteen falling edges per frame, then locks out.
// - Standalone mode samples the strobe at sync fall; low means update on edge sixteen.
module dac_serial_load_chain
	import dac_load_pkg::*;
(
	input  wire logic                mclk,
	input  wire logic                nrst,
	input  wire logic                sclk,
	input  wire logic                serial_in,
	input  wire logic                sync_n,
	input  wire logic                chain_select,
	input  wire logic                latch_load_n,
	input  wire logic                latch_zero_n,
	output logic                     serial_out,
	output dac_load_pkg::word_t      dac_code,
	output logic                     word_valid,
	input  wire logic                word_ready,
	output dac_load_pkg::word_t      word_data
);
	import dac_load_pkg::*;

	// Two-stage synchronisers for every pin except mclk, nrst and word_ready.
	logic [5:0] pin_meta;
	logic [5:0] pin_sync;
	logic [5:0] pin_prev;
	logic [5:0] next_pin_meta;
	logic [5:0] next_pin_sync;
	logic [5:0] next_pin_prev;
	logic       s_sclk;
	logic       s_din;
	logic       s_sync_n;
	logic       s_chain;
	logic       s_load_n;
	logic       s_zero_n;
	logic       sclk_fall;
	logic       sync_fall;
	logic       load_fall;

	always_comb begin
		next_pin_meta = {latch_zero_n, latch_load_n, chain_select, sync_n, serial_in, sclk};
		next_pin_sync = pin_meta;
		next_pin_prev = pin_sync;
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			pin_meta <= 6'h3d;
			pin_sync <= 6'h3d;
			pin_prev <= 6'h3d;
		end else begin
			pin_meta <= next_pin_meta;
			pin_sync <= next_pin_sync;
			pin_prev <= next_pin_prev;
		end
	end

	assign s_sclk    = pin_sync[0];
	assign s_din     = pin_sync[1];
	assign s_sync_n  = pin_sync[2];
	assign s_chain   = pin_sync[3];
	assign s_load_n  = pin_sync[4];
	assign s_zero_n  = pin_sync[5];
	assign sclk_fall = pin_prev[0] && !s_sclk;
	assign sync_fall = pin_prev[2] && !s_sync_n;
	assign load_fall = pin_prev[4] && !s_load_n;

	// Frame sequencing and the input shift register.
	frame_state_t state;
	frame_state_t next_state;
	logic [4:0]   edge_count;
	logic [4:0]   next_edge_count;
	word_t        shift_reg;
	word_t        next_shift_reg;
	logic         auto_mode;
	logic         next_auto_mode;
	logic         sout;
	logic         next_sout;
	logic         shift_en;
	logic         word_done;

	always_comb begin
		next_state      = state;
		next_edge_count = edge_count;
		next_shift_reg  = shift_reg;
		next_auto_mode  = auto_mode;
		next_sout       = sout;
		shift_en        = 1'b0;
		word_done       = 1'b0;
		case (state)
			frame_idle: begin
				if (sync_fall) begin
					next_state      = frame_active;
					next_edge_count = 5'h00;
					next_auto_mode  = !s_load_n && !s_chain;
				end
			end
			frame_active: begin
				if (s_sync_n) begin
					next_state = frame_idle;
				end else if (sclk_fall) begin
					shift_en = 1'b1;
					if (!s_chain) begin
						next_edge_count = edge_count + 5'h01;
						if (edge_count == 5'h0f) begin
							word_done  = 1'b1;
							next_state = frame_locked;
						end
					end
				end
			end
			frame_locked: begin
				if (s_sync_n) begin
					next_state = frame_idle;
				end
			end
			default: begin
				next_state = frame_idle;
			end
		endcase
		if (shift_en) begin
			next_shift_reg = {shift_reg[14:0], s_din};
			next_sout      = shift_reg[15];
		end
		if (!s_chain) begin
			next_sout = 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			state      <= frame_idle;
			edge_count <= 5'h00;
			shift_reg  <= `WORD_RESET;
			auto_mode  <= 1'b0;
			sout       <= 1'b0;
		end else begin
			state      <= next_state;
			edge_count <= next_edge_count;
			shift_reg  <= next_shift_reg;
			auto_mode  <= next_auto_mode;
			sout       <= next_sout;
		end
	end

	// Converter latch and track-and-hold of the output.
	localparam int HOLD_CYCLES = `HOLD_CYCLES;
	word_t        latch;
	word_t        next_latch;
	word_t        held;
	word_t        next_held;
	logic [8:0]   hold_count;
	logic [8:0]   next_hold_count;
	logic         push_word;
	word_t        push_data;
	logic         push_ready;

	always_comb begin
		next_latch      = latch;
		next_held       = held;
		next_hold_count = hold_count;
		push_word       = 1'b0;
		push_data       = next_shift_reg;
		if (word_done && auto_mode) begin
			next_latch = next_shift_reg;
			next_held  = next_shift_reg;
			push_word  = 1'b1;
		end else if (load_fall) begin
			next_latch      = shift_reg;
			next_hold_count = HOLD_CYCLES[8:0];
			push_data       = shift_reg;
			push_word       = 1'b1;
		end
		if (!s_zero_n) begin
			next_latch      = `WORD_RESET;
			next_held       = `WORD_RESET;
			next_hold_count = 9'h000;
			push_word       = 1'b0;
		end else if (hold_count != 9'h000) begin
			next_hold_count = hold_count - 9'h001;
			if (hold_count == 9'h001) begin
				next_held = latch;
			end
		end
		// A full queue drops the word, as the pins cannot be held off.
		push_word = push_word && push_ready;
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			latch      <= `WORD_RESET;
			held       <= `WORD_RESET;
			hold_count <= 9'h000;
		end else begin
			latch      <= next_latch;
			held       <= next_held;
			hold_count <= next_hold_count;
		end
	end

	// Each latch value taken from the shift register is also queued for the consumer downstream unless the queue is full; the zero loaded by clear is not.
	word_fifo #(
		.WIDTH(`WORD_BITS),
		.DEPTH(`FIFO_DEPTH)
	) u_fifo (
		.mclk      (mclk),
		.nrst      (nrst),
		.in_valid  (push_word),
		.in_ready  (push_ready),
		.in_data   (push_data),
		.out_valid (word_valid),
		.out_ready (word_ready),
		.out_data  (word_data)
	);

	assign serial_out = sout;
	assign dac_code   = held;
endmodule
`default_nettype wire

//--- rtl/word_fifo.sv
// First-in first-out buffer for converter words.
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 32
) (
	input  wire logic             mclk,
	input  wire logic             nrst,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic [AW-1:0]    next_wr_ptr;
	logic [AW-1:0]    next_rd_ptr;
	logic [AW:0]      next_count;
	logic             next_out_valid;
	logic [WIDTH-1:0] next_out_data;
	logic             push;
	logic             pop;

	always_comb begin
		in_ready    = (count != DEPTH[AW:0]);
		push        = in_valid && in_ready;
		pop         = out_valid && out_ready;
		next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
		next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
		next_count  = count;
		if (push && !pop) begin
			next_count = count + 1'b1;
		end else if (pop && !push) begin
			next_count = count - 1'b1;
		end
		next_out_valid = (next_count != '0);
		next_out_data  = mem[next_rd_ptr];
		if (push && (wr_ptr == next_rd_ptr)) begin
			// A word written while the queue drains to empty goes straight to the head.
			next_out_data = in_data;
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			wr_ptr    <= '0;
			rd_ptr    <= '0;
			count     <= '0;
			out_valid <= 1'b0;
			out_data  <= '0;
		end else begin
			wr_ptr    <= next_wr_ptr;
			rd_ptr    <= next_rd_ptr;
			count     <= next_count;
			out_valid <= next_out_valid;
			out_data  <= next_out_data;
		end
	end

	always_ff @(posedge mclk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end
endmodule
`default_nettype wire

//--- verification/dac_load_asserts.sv
// Port checker for the serial load chain.
`timescale 1ns/1ps
`default_nettype none
module dac_load_asserts (
	input wire logic        mclk,
	input wire logic        nrst,
	input wire logic        sclk,
	input wire logic        serial_in,
	input wire logic        sync_n,
	input wire logic        chain_select,
	input wire logic        latch_load_n,
	input wire logic        latch_zero_n,
	input wire logic        serial_out,
	input wire logic [15:0] dac_code,
	input wire logic        word_valid,
	input wire logic        word_ready,
	input wire logic [15:0] word_data
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	clear_zero_a: assert property ((!latch_zero_n) [*3] |=> dac_code == 16'h0000)
		else $error("clear left code");
	clear_push_a: assert property ((!latch_zero_n && latch_load_n && sync_n && !word_valid) [*4]
		|=> !word_valid) else $error("clear pushed a word");
	chain_off_a: assert property ((!chain_select) [*4] |=> !serial_out)
		else $error("serial out active");
	out_hold_a: assert property ((sync_n && chain_select) [*4] |=> $stable(serial_out))
		else $error("serial out moved");
	strobe_hold_a: assert property ($fell(latch_load_n) && latch_zero_n && sync_n
		|=> $stable(dac_code) [*8]) else $error("no output hold");
	fifo_valid_a: assert property (word_valid && !word_ready |=> word_valid)
		else $error("word lost");
	fifo_data_a: assert property (word_valid && !word_ready |=> $stable(word_data))
		else $error("head word moved");
	reset_out_a: assert property (disable iff (1'b0) !nrst |=> dac_code == 16'h0000
		&& !serial_out && !word_valid) else $error("reset left outputs");
endmodule
bind dac_serial_load_chain dac_load_asserts chk (.mclk(mclk), .nrst(nrst), .sclk(sclk),
	.serial_in(serial_in), .sync_n(sync_n), .chain_select(chain_select),
	.latch_load_n(latch_load_n), .latch_zero_n(latch_zero_n), .serial_out(serial_out),
	.dac_code(dac_code), .word_valid(word_valid), .word_ready(word_ready),
	.word_data(word_data));
`default_nettype wire

//--- verification/dac_serial_load_chain_tb.sv
// Self-checking bench of the serial load chain.
`timescale 1ns/1ps
`default_nettype none
module dac_serial_load_chain_tb;
	logic        mclk, nrst, chain_select, latch_load_n, latch_zero_n, word_ready;
	logic        sclk, serial_in, sync_n, serial_out, word_valid;
	logic [15:0] dac_code, word_data, w0, w1, w2, last, seen;
	logic [31:0] rnd;
	int          mismatches, compares, n;
	dac_serial_load_chain dut (.mclk(mclk), .nrst(nrst), .sclk(sclk), .serial_in(serial_in),
		.sync_n(sync_n), .chain_select(chain_select), .latch_load_n(latch_load_n),
		.latch_zero_n(latch_zero_n), .serial_out(serial_out), .dac_code(dac_code),
		.word_valid(word_valid), .word_ready(word_ready), .word_data(word_data));
	host_link_model host (.mclk(mclk), .serial_out(serial_out), .sclk(sclk),
		.serial_in(serial_in), .sync_n(sync_n), .seen(seen));
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		return s ^ (s << 5);
	endfunction
	function automatic logic [15:0] fifo_exp(input int i);
		if (i == 0)
			return 16'h0000;
		return (i < 3) ? w0 : 16'h8001;
	endfunction
	function automatic logic [15:0] dac_exp(input logic ch, input logic ld,
		input logic [15:0] w, input logic [15:0] old);
		return (!ch && !ld) ? w : old;
	endfunction
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic end_sim;
		$display("mismatches %0d compares %0d", mismatches, compares);
		if (mismatches == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic strobe(input int k);
		latch_load_n = 1'b0;
		host.tick(k);
		latch_load_n = 1'b1;
		host.tick(6);
	endtask
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	// A hang past the expected run length counts as a failure.
	initial begin
		host.tick(6000);
		mismatches++;
		end_sim();
	end
	initial begin
		{nrst, chain_select, latch_load_n, latch_zero_n, word_ready} = 5'b00110;
		rnd = xs(32'h00000026);
		w0 = rnd[15:0];
		rnd = xs(rnd);
		w1 = rnd[15:0];
		host.tick(16);
		nrst = 1'b1;
		host.tick(3);
		check(dac_code, 16'h0000);
		latch_zero_n = 1'b0;
		host.tick(6);
		latch_zero_n = 1'b1;
		check({15'h0000, word_valid}, 16'h0000);
		latch_load_n = 1'b0;
		host.send({12'h000, w0, 4'ha}, 20, 1'b1);
		check(dac_code, w0);
		check(seen, 16'h0000);
		latch_load_n = 1'b1;
		host.tick(6);
		strobe(210);
		check(dac_code, w0);
		chain_select = 1'b1;
		host.send({w1, 16'h8001}, 32, 1'b1);
		check(seen, w1);
		host.tick(4);
		host.send(rnd, 4, 1'b0);
		latch_load_n = 1'b0;
		host.tick(100);
		check(dac_code, w0);
		host.tick(110);
		check(dac_code, 16'h8001);
		latch_load_n = 1'b1;
		host.tick(6);
		latch_zero_n = 1'b0;
		host.tick(6);
		check(dac_code, 16'h0000);
		latch_zero_n = 1'b1;
		strobe(210);
		check(dac_code, 16'h8001);
		for (int i = 0; i < 30; i++)
			strobe(6);
		// The strobe fall that opened the first frame queued the reset content first.
		check(word_data, 16'h0000);
		repeat (200) begin
			rnd = xs(rnd);
			word_ready = rnd[0];
			if (word_valid === 1'b1 && word_ready === 1'b1) begin
				check(word_data, fifo_exp(n));
				n++;
			end
			host.tick(1);
		end
		check(n[15:0], 16'h0020);
		check({15'h0000, word_valid}, 16'h0000);
		last = 16'h8001;
		repeat (3) begin
			rnd = xs(rnd);
			w2 = rnd[15:0];
			chain_select = rnd[16];
			latch_load_n = rnd[17];
			host.send({16'h0000, w2}, 16, 1'b1);
			check(dac_code, dac_exp(chain_select, latch_load_n, w2, last));
			latch_load_n = 1'b1;
			host.tick(6);
			strobe(210);
			check(dac_code, w2);
			latch_zero_n = rnd[19];
			host.tick(6);
			last = rnd[19] ? w2 : 16'h0000;
			check(dac_code, last);
			latch_zero_n = 1'b1;
			host.tick(2);
		end
		end_sim();
	end
endmodule
`default_nettype wire

//--- verification/host_link_model.sv
// Host side of the three-wire serial link.
`timescale 1ns/1ps
`default_nettype none
module host_link_model (
	input  wire logic        mclk,
	input  wire logic        serial_out,
	output logic             sclk,
	output logic             serial_in,
	output logic             sync_n,
	output logic [15:0]      seen
);
	initial begin
		sclk = 1'b1;
		serial_in = 1'b0;
		sync_n = 1'b1;
		seen = 16'h0000;
	end
	task automatic tick(input int k);
		repeat (k) @(posedge mclk);
		#1;
	endtask
	// Sends n bits, top bit first; frame sync is low only when frm is set.
	task automatic send(input logic [31:0] d, input int n, input logic frm);
		sync_n = !frm;
		tick(4);
		for (int i = n - 1; i >= 0; i--) begin
			serial_in = d[i];
			tick(4);
			sclk = 1'b0;
			tick(4);
			seen = {seen[14:0], serial_out};
			sclk = 1'b1;
			serial_in = ~d[i];
		end
		tick(4);
		sync_n = 1'b1;
	endtask
endmodule
`default_nettype wire
